// >>> design/dcv_debug_core.sv
// Purpose: halting debug register transfer, resume address and vector catch control
// Assumes: core side signals are on clk; apb slave with zero wait states
// Notes:   rst is the power-on reset, localRst the core-local reset

// Behaviour
// RULE1: breakpoint halt resumes at breakpointed instruction
// RULE2: other events resume at next unexecuted instruction
// RULE3: earlier instructions complete before halting
// RULE4: resume address bit 0 reads zero, ignored
// RULE5: 32-bit transfer data register holds moved word
// RULE6: debugger treats transfer data undefined when indicated
// RULE7: selector write clears done; completion sets it
// RULE8: debugger writes core register via data first
// RULE9: debugger reads core register after done
// RULE10: transfer writes reach all status bits
// RULE11: leaving debug starts at overwritten resume address
// RULE12: power-on reset clears monitor control
// RULE13: local reset clears only watch enable
// RULE14: bit 24 globally enables watch unit
// RULE15: bit 10 traps hardfault when debug enabled
// RULE16: bit 0 catches local reset when enabled
// RULE17: caught exception halts at handler's first instruction
// RULE18: vector catch halts before any later instruction
// RULE19: late or derived exceptions may postpone catch
// RULE20: vector catch sets debug fault status bits
// RULE21: selector index bits 4:0, direction bit 16
// RULE22: reserved control bits read zero, ignore writes
module dcv_debug_core (
  // clock and resets
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        localRst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // debug events from the core
  input  wire logic        dbgEvent,
  input  wire logic        dbgEventIsBkpt,
  input  wire logic [31:0] bkptPc,
  input  wire logic [31:0] nextPc,
  input  wire logic        coreQuiet,
  // exception entry from the core
  input  wire logic        excActive,
  input  wire logic        excIsHardFault,
  input  wire logic        excIsReset,
  input  wire logic        excPostpone,
  input  wire logic [31:0] handlerPc,
  // halt and resume control to the core
  output logic             coreHaltReq,
  output logic             inDebug,
  output logic             coreResume,
  output logic [31:0]      coreResumePc,
  // core register transfer port
  output logic             coreRegReq,
  output logic             coreRegWrite,
  output logic [4:0]       coreRegIdx,
  output logic [31:0]      coreRegWdata,
  input  wire logic [31:0] coreRegRdata,
  input  wire logic        coreRegAck,
  // side outputs
  output logic             watchUnitEnable,
  output logic             vcatchFaultSet
);
  import dcv_pkg::*;

  // register map as the debugger sees it
  //   selector      : index in the low five bits, direction above them
  //   transfer data : the word moved to or from the selected core register
  //   monitor ctl   : watch unit enable, hardfault catch, reset catch
  //   halt ctl/stat : debug enable, halt request, done, halted, catch flag
  // halt request stays set once halted; clearing it is the resume command
  // the catch flag is write-one-to-clear; a new catch wins over the clear
  // unmapped offsets answer with an error, read zero and drop writes
  //
  // transfer flow
  //   a selector write in debug state latches index and direction apart
  //   from the selector, so a careless rewrite cannot retarget a move
  //   the resume address index is served here, every other index goes out
  //   on the core register port and waits for its acknowledge
  //   done drops at the selector write and rises when the move lands
  //
  // halt flow
  //   run -> drain on an event, drain -> halted once the core is quiet,
  //   halted -> exit when the halt request is cleared, exit -> run
  //   a catch that meets a postponed exception entry is held pending and
  //   taken as soon as the core stops postponing
  //
  // resets
  //   power-on reset clears every control bit and the transfer state
  //   local reset only drops the watch unit enable; both catch enables
  //   and the debug state survive it

  typedef struct packed {
    // bookkeeping of the halt sequence
    dcv_state_t  state;
    // selector as written, and the target of the move in flight
    logic [4:0]  selIdx;
    logic        selDir;
    logic [4:0]  xferIdx;
    logic        xferDir;
    logic [31:0] xferData;
    // control bits the debugger writes
    logic        debugEn;
    logic        haltReq;
    logic        watchEn;
    logic        hardCatch;
    logic        rstCatch;
    // resume point and what caused the halt
    logic [31:0] resumeAddr;
    logic        evtBkpt;
    logic        evtVcatch;
    logic        vcatchPend;
    logic        done;
    logic        busy;
    logic        vcatchFlag;
    logic        vcatchPulse;
    logic        resumePulse;
    // bus answer held in flip-flops
    logic [31:0] rdata;
    logic        slvErr;
  } dcv_regs_t;

  dcv_regs_t s_r;
  dcv_regs_t s_nxt;

  logic        setup;
  logic        wrAcc;
  logic        catchRaw;
  logic        catchHit;
  logic [31:0] monCtl;
  logic [31:0] haltCs;

  // decode of an offset against the register map, used by read and write
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == DCV_OFS_SELECTOR) || (a == DCV_OFS_XFER) ||
               (a == DCV_OFS_MONCTL) || (a == DCV_OFS_HALTCS);
  endfunction

  // clear bit 0 of an address; used on capture and on debugger writes
  function automatic logic [31:0] halfAlign(input logic [31:0] a);
    halfAlign = {a[31:1], 1'b0};
  endfunction

  // read views; reserved bits stay zero
  always_comb begin
    monCtl = DCV_ZERO;
    monCtl[MON_WATCH_EN_BIT]   = s_r.watchEn;   // [RULE22]
    monCtl[MON_HARD_CATCH_BIT] = s_r.hardCatch;
    monCtl[MON_RST_CATCH_BIT]  = s_r.rstCatch;
    haltCs = DCV_ZERO;
    haltCs[HCS_DEBUG_EN_BIT] = s_r.debugEn;
    haltCs[HCS_HALT_REQ_BIT] = s_r.haltReq;
    haltCs[HCS_DONE_BIT]     = s_r.done;
    haltCs[HCS_HALTED_BIT]   = (s_r.state == DCV_HALT);
    haltCs[HCS_VCATCH_BIT]   = s_r.vcatchFlag;
  end

  // a catch needs debug enabled, its enable set and the exception active
  assign catchRaw = s_r.debugEn && excActive &&
                    ((excIsHardFault && s_r.hardCatch) ||              // [RULE15] [RULE17]
                     (excIsReset && s_r.rstCatch));                    // [RULE16]

  // postponement delays the halt, it never cancels it
  assign catchHit = (catchRaw || s_r.vcatchPend) && !excPostpone;      // [RULE19]

  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pwrite;

  // next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.vcatchPulse = 1'b0;
    s_nxt.resumePulse = 1'b0;

    // read data is prepared in the setup cycle so it leaves a flip-flop
    if (setup) begin
      s_nxt.slvErr = !isMapped(paddr);
      case (paddr)
        DCV_OFS_SELECTOR: begin
          s_nxt.rdata = DCV_ZERO;
          s_nxt.rdata[SEL_IDX_LSB +: SEL_IDX_W] = s_r.selIdx;
          s_nxt.rdata[SEL_DIR_BIT] = s_r.selDir;
        end
        DCV_OFS_XFER:   s_nxt.rdata = s_r.xferData;                      // [RULE5]
        DCV_OFS_MONCTL: s_nxt.rdata = monCtl;
        DCV_OFS_HALTCS: s_nxt.rdata = haltCs;
        default:        s_nxt.rdata = DCV_ZERO;
      endcase
    end

    // register writes take effect at the access edge
    if (wrAcc) begin
      case (paddr)
        DCV_OFS_XFER: begin
          // the word in flight to the core stays put until the move lands
          if (!s_r.busy) begin
            s_nxt.xferData = pwdata;                                     // [RULE5]
          end
        end
        DCV_OFS_MONCTL: begin
          s_nxt.watchEn   = pwdata[MON_WATCH_EN_BIT];                    // [RULE14]
          s_nxt.hardCatch = pwdata[MON_HARD_CATCH_BIT];
          s_nxt.rstCatch  = pwdata[MON_RST_CATCH_BIT];
        end
        DCV_OFS_HALTCS: begin
          s_nxt.debugEn = pwdata[HCS_DEBUG_EN_BIT];
          s_nxt.haltReq = pwdata[HCS_HALT_REQ_BIT];
          // writing the status word with the catch bit set clears it
          if (pwdata[HCS_VCATCH_BIT]) begin
            s_nxt.vcatchFlag = 1'b0;
          end
        end
        DCV_OFS_SELECTOR: begin
          s_nxt.selIdx = pwdata[SEL_IDX_LSB +: SEL_IDX_W];               // [RULE21]
          s_nxt.selDir = pwdata[SEL_DIR_BIT];
          // a new transfer starts only in debug state and not over a running one
          if (s_r.state == DCV_HALT && !s_r.busy) begin
            s_nxt.xferIdx = pwdata[SEL_IDX_LSB +: SEL_IDX_W];            // [RULE21]
            s_nxt.xferDir = pwdata[SEL_DIR_BIT];
            s_nxt.done = 1'b0;                                           // [RULE7]
            s_nxt.busy = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // transfer engine; the resume address is kept locally, all else goes to the core
    if (s_r.busy) begin
      if (s_r.xferIdx == IDX_RESUME) begin
        if (s_r.xferDir) begin
          s_nxt.resumeAddr = halfAlign(s_r.xferData);                    // [RULE4] [RULE11]
        end else begin
          s_nxt.xferData = halfAlign(s_r.resumeAddr);                    // [RULE4]
        end
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;                                               // [RULE7]
      end else if (coreRegAck) begin
        // psr writes carry the full word; the core applies every bit
        if (!s_r.xferDir) begin
          s_nxt.xferData = coreRegRdata;                                 // [RULE10]
        end
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;                                               // [RULE7]
      end
    end

    // a catch held off by a late or derived exception entry waits here;
    // dropping it instead would lose the halt the debugger asked for
    if (catchRaw && excPostpone) begin
      s_nxt.vcatchPend = 1'b1;                                           // [RULE19]
    end
    // disabling halting debug forgets a pending catch
    if (!s_r.debugEn) begin
      s_nxt.vcatchPend = 1'b0;
    end

    // halt sequencing
    case (s_r.state)
      DCV_RUN: begin
        if (catchHit) begin
          // the handler has not run yet, so it resumes at its first word
          s_nxt.resumeAddr  = halfAlign(handlerPc);                      // [RULE17] [RULE18]
          s_nxt.vcatchFlag  = 1'b1;                                      // [RULE20]
          s_nxt.vcatchPulse = 1'b1;                                      // [RULE20]
          s_nxt.evtVcatch   = 1'b1;
          s_nxt.vcatchPend  = 1'b0;
          s_nxt.state       = DCV_DRAIN;
        end else if (s_r.debugEn && dbgEvent) begin
          s_nxt.evtBkpt   = dbgEventIsBkpt;
          s_nxt.evtVcatch = 1'b0;
          if (dbgEventIsBkpt) begin
            s_nxt.resumeAddr = halfAlign(bkptPc);                        // [RULE1]
          end
          s_nxt.state = DCV_DRAIN;
        end else if (s_r.debugEn && s_r.haltReq) begin
          s_nxt.evtBkpt   = 1'b0;
          s_nxt.evtVcatch = 1'b0;
          s_nxt.state     = DCV_DRAIN;
        end
      end
      DCV_DRAIN: begin
        // debug state is entered only once older instructions have retired
        if (coreQuiet) begin                                             // [RULE3]
          if (!s_r.evtBkpt && !s_r.evtVcatch) begin
            s_nxt.resumeAddr = halfAlign(nextPc);                        // [RULE2]
          end
          s_nxt.haltReq = 1'b1;
          s_nxt.done    = 1'b1;
          s_nxt.state   = DCV_HALT;
        end
      end
      DCV_HALT: begin
        // resume waits for any transfer in flight so the core port is idle
        if (!s_r.haltReq && !s_r.busy) begin
          s_nxt.resumePulse = 1'b1;
          s_nxt.state       = DCV_EXIT;
        end
      end
      DCV_EXIT: begin
        s_nxt.evtBkpt   = 1'b0;
        s_nxt.evtVcatch = 1'b0;
        s_nxt.state     = DCV_RUN;
      end
      default: s_nxt.state = DCV_RUN;
    endcase

    // local reset drops the watch unit but keeps both catch enables
    if (localRst) begin
      s_nxt.watchEn = 1'b0;                                              // [RULE13]
    end
  end

  // one register bank; power-on reset clears every control bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r.state       <= DCV_RUN;
      s_r.selIdx      <= 5'h00;
      s_r.selDir      <= 1'b0;
      s_r.xferIdx     <= 5'h00;
      s_r.xferDir     <= 1'b0;
      s_r.xferData    <= DCV_ZERO;
      s_r.debugEn     <= 1'b0;
      s_r.haltReq     <= 1'b0;
      s_r.watchEn     <= MON_RESET_VAL[MON_WATCH_EN_BIT];                // [RULE12]
      s_r.hardCatch   <= MON_RESET_VAL[MON_HARD_CATCH_BIT];              // [RULE12]
      s_r.rstCatch    <= MON_RESET_VAL[MON_RST_CATCH_BIT];               // [RULE12]
      s_r.resumeAddr  <= DCV_ZERO;
      s_r.evtBkpt     <= 1'b0;
      s_r.evtVcatch   <= 1'b0;
      s_r.vcatchPend  <= 1'b0;
      s_r.done        <= 1'b0;
      s_r.busy        <= 1'b0;
      s_r.vcatchFlag  <= 1'b0;
      s_r.vcatchPulse <= 1'b0;
      s_r.resumePulse <= 1'b0;
      s_r.rdata       <= DCV_ZERO;
      s_r.slvErr      <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // apb answer: zero wait states, data and error from flip-flops
  assign pready  = 1'b1;
  assign prdata  = s_r.rdata;
  assign pslverr = s_r.slvErr && psel && penable;

  // core side
  assign coreHaltReq     = (s_r.state == DCV_DRAIN);                     // [RULE18]
  assign inDebug         = (s_r.state == DCV_HALT);
  assign coreResume      = s_r.resumePulse;
  assign coreResumePc    = s_r.resumeAddr;                               // [RULE11]
  assign coreRegReq      = s_r.busy && (s_r.xferIdx != IDX_RESUME);
  assign coreRegWrite    = s_r.xferDir;
  assign coreRegIdx      = s_r.xferIdx;
  assign coreRegWdata    = s_r.xferData;                                 // [RULE10]
  assign watchUnitEnable = s_r.watchEn;                                  // [RULE14]
  assign vcatchFaultSet  = s_r.vcatchPulse;                              // [RULE20]

  // limitations
  //   only one move is in flight; a selector write while busy is stored
  //   but starts nothing, so the debugger must poll done first
  //   transfer data writes while busy are dropped to keep the word stable
  //   transfer data is not cleared on leaving debug state; the debugger
  //   must treat it as stale while the core runs
  //   a catch that meets a halt already in progress is not queued unless the exception entry is postponed
  //   the core must hold coreQuiet low until older work has retired,
  //   since the resume address for plain events is taken at that edge

endmodule

// >>> design/dcv_pkg.sv
// Purpose: shared constants for the debug core register access and vector catch block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   offsets of the bus registers are local choices

package dcv_pkg;

  // register byte offsets on the apb
  localparam logic [11:0] DCV_OFS_SELECTOR = 12'h000;
  localparam logic [11:0] DCV_OFS_XFER     = 12'h004;
  localparam logic [11:0] DCV_OFS_MONCTL   = 12'h008;
  localparam logic [11:0] DCV_OFS_HALTCS   = 12'h00c;

  // core_reg_selector fields
  localparam int SEL_IDX_LSB = 0;
  localparam int SEL_IDX_W   = 5;
  localparam int SEL_DIR_BIT = 16;

  // debug_monitor_control fields
  localparam int MON_WATCH_EN_BIT  = 24;
  localparam int MON_HARD_CATCH_BIT = 10;
  localparam int MON_RST_CATCH_BIT = 0;
  localparam logic [31:0] MON_RESET_VAL = 32'h0000_0000;

  // halt_control_status fields
  localparam int HCS_DEBUG_EN_BIT = 0;
  localparam int HCS_HALT_REQ_BIT = 1;
  localparam int HCS_DONE_BIT     = 16;
  localparam int HCS_HALTED_BIT   = 17;
  localparam int HCS_VCATCH_BIT   = 18;

  // register indices named by this block; only the resume index is served inside it
  localparam logic [4:0] IDX_RESUME = 5'h0f;
  localparam logic [4:0] IDX_PSR    = 5'h10;

  localparam logic [31:0] DCV_ZERO = 32'h0000_0000;

  // halt sequencing, gray coded along run, drain, halted, exit
  typedef enum logic [1:0] {
    DCV_RUN   = 2'b00,
    DCV_DRAIN = 2'b01,
    DCV_HALT  = 2'b11,
    DCV_EXIT  = 2'b10
  } dcv_state_t;

endpackage

// >>> testbench/dcv_debug_core_assertions.sv
// Purpose: port level checks for the debug core block
// Assumes: one clock, rst disables every check
// Notes:   pwdata is sampled by the checker only on monitor control writes
module dcv_debug_core_assertions
  import dcv_pkg::*;
(
  // clock and resets
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        localRst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // core side
  input wire logic        coreHaltReq,
  input wire logic        coreQuiet,
  input wire logic        excPostpone,
  input wire logic        inDebug,
  input wire logic        coreResume,
  input wire logic [31:0] coreResumePc,
  input wire logic        coreRegReq,
  input wire logic        coreRegAck,
  input wire logic [4:0]  coreRegIdx,
  input wire logic        watchUnitEnable,
  input wire logic        vcatchFaultSet
);
  timeunit 1ns;
  timeprecision 1ps;
  // completed write to the monitor control word
  logic monWr;
  assign monWr = psel && penable && pwrite && paddr == DCV_OFS_MONCTL;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_drain_done;
    coreHaltReq && coreQuiet;
  endsequence
  sequence s_watch_set;
    monWr && !localRst && pwdata[MON_WATCH_EN_BIT];
  endsequence

  chk_halt_entry: assert property (s_drain_done |=> inDebug)
    else $error("no halt after core went quiet");
  chk_resume_even: assert property (coreResume |-> !coreResumePc[0])
    else $error("resume address bit 0 set");
  chk_resume_leave: assert property (coreResume |=> !inDebug && !coreResume)
    else $error("resume pulse malformed");
  chk_req_hold: assert property (coreRegReq && !coreRegAck |=> coreRegReq && $stable(coreRegIdx))
    else $error("core transfer dropped early");
  chk_req_halted: assert property (coreRegReq |-> inDebug)
    else $error("core transfer outside debug");
  chk_local_clear: assert property (localRst |=> !watchUnitEnable)
    else $error("local reset kept watch enable");
  chk_watch_set: assert property (s_watch_set |=> watchUnitEnable)
    else $error("watch enable not set");
  chk_watch_hold: assert property (!monWr && !localRst |=> $stable(watchUnitEnable))
    else $error("watch enable moved alone");
  chk_catch_halts: assert property (vcatchFaultSet |-> ##[0:4] (coreHaltReq || inDebug))
    else $error("catch without halt");
  chk_postpone_hold: assert property (excPostpone |=> !vcatchFaultSet)
    else $error("catch taken while postponed");
endmodule

bind dcv_debug_core dcv_debug_core_assertions u_chk (
  .clk, .rst, .localRst, .psel, .penable, .pwrite, .paddr, .pwdata, .coreHaltReq,
  .coreQuiet, .excPostpone, .inDebug, .coreResume, .coreResumePc, .coreRegReq, .coreRegAck,
  .coreRegIdx, .watchUnitEnable, .vcatchFaultSet
);

// >>> testbench/dcv_core_model.sv
// Purpose: behavioural core register file answering the transfer port
// Assumes: one transfer outstanding at a time
// Notes:   read data toggles while idle so stale values never match
module dcv_core_model (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        slow,
  // transfer port
  input wire logic        coreRegReq,
  input wire logic        coreRegWrite,
  input wire logic [4:0]  coreRegIdx,
  input wire logic [31:0] coreRegWdata,
  output logic [31:0]     coreRegRdata,
  output logic            coreRegAck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs [32];
  int          cnt;

  // answer after zero or three wait cycles, whole word kept
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      coreRegAck <= 1'b0;
      coreRegRdata <= 32'h5a5a_5a5a;
      cnt <= 0;
    end else if (coreRegAck || !coreRegReq) begin
      coreRegAck <= 1'b0;
      coreRegRdata <= ~coreRegRdata;
    end else if (cnt < (slow ? 3 : 0)) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
      coreRegAck <= 1'b1;
      if (coreRegWrite) regs[coreRegIdx] <= coreRegWdata;
      coreRegRdata <= coreRegWrite ? ~coreRegWdata : regs[coreRegIdx];
    end
  end
endmodule

// >>> testbench/debug_core_reg_access_vector_catch_tb.sv
// Purpose: self-checking bench for the debug core block
// Assumes: zero wait apb, core register file modelled
// Notes:   checks sampled on the falling edge or after access edges
module debug_core_reg_access_vector_catch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dcv_pkg::*;
  logic clk, rst, localRst, psel, penable, pwrite, pready, pslverr, lastErr, slow;
  logic dbgEvent, dbgEventIsBkpt, coreQuiet, excActive, excIsHardFault, excIsReset;
  logic excPostpone, coreHaltReq, inDebug, coreResume, coreRegReq, coreRegWrite;
  logic coreRegAck, watchUnitEnable, vcatchFaultSet;
  logic [11:0] paddr;
  logic [4:0]  coreRegIdx, idx;
  logic [31:0] pwdata, prdata, bkptPc, nextPc, handlerPc, coreResumePc;
  logic [31:0] coreRegWdata, coreRegRdata, rd, pc, d;
  int          n_errors, n_compared, seed, k, j, nVc, nV0;

  dcv_debug_core u_dut (.clk, .rst, .localRst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .dbgEvent, .dbgEventIsBkpt, .bkptPc, .nextPc,
    .coreQuiet, .excActive, .excIsHardFault, .excIsReset, .excPostpone, .handlerPc,
    .coreHaltReq, .inDebug, .coreResume, .coreResumePc, .coreRegReq, .coreRegWrite,
    .coreRegIdx, .coreRegWdata, .coreRegRdata, .coreRegAck, .watchUnitEnable,
    .vcatchFaultSet);
  dcv_core_model u_core (.clk, .rst, .slow, .coreRegReq, .coreRegWrite, .coreRegIdx,
    .coreRegWdata, .coreRegRdata, .coreRegAck);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // catch pulses counted apart from the main flow
  always @(posedge clk) if (vcatchFaultSet === 1'b1) nVc <= nVc + 1;

  function automatic logic [31:0] even(input logic [31:0] a);
    return {a[31:1], 1'b0};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, an idle cycle ahead keeps drives one per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic xfer(input logic [4:0] i, input logic wr, input logic [31:0] wd,
                      output logic [31:0] r);
    logic [31:0] s;
    int n;
    if (wr) apb(1'b1, DCV_OFS_XFER, wd, r);
    apb(1'b1, DCV_OFS_SELECTOR, {15'h0, wr, 11'h0, i}, r);
    apb(1'b0, DCV_OFS_HALTCS, 32'h0, s);
    if (i != IDX_RESUME) chk("done cleared", 32'h0, 32'(s[HCS_DONE_BIT]));
    for (n = 0; n < 40 && s[HCS_DONE_BIT] !== 1'b1; n++) apb(1'b0, DCV_OFS_HALTCS, 32'h0, s);
    chk("done set", 32'h1, 32'(s[HCS_DONE_BIT]));
    if (!wr) apb(1'b0, DCV_OFS_XFER, 32'h0, r);
  endtask

  // kind 0 breakpoint, 1 other event, 2 hardfault, 3 local reset entry
  task automatic halt_on(input int t, input logic [31:0] a, input logic go);
    int n;
    @(posedge clk);
    coreQuiet <= 1'b0;
    dbgEvent <= (t < 2);
    dbgEventIsBkpt <= (t == 0);
    excActive <= (t > 1);
    excIsHardFault <= (t == 2);
    excIsReset <= (t == 3);
    bkptPc <= (t == 0) ? a : ~a;
    nextPc <= (t == 1) ? a : ~a;
    handlerPc <= (t > 1) ? a : ~a;
    @(posedge clk);
    dbgEvent <= 1'b0;
    excActive <= 1'b0;
    repeat (3) @(posedge clk);
    coreQuiet <= 1'b1;
    @(negedge clk);
    chk("halt before quiet", 32'h0, 32'(inDebug));
    for (n = 0; n < 10 && inDebug !== 1'b1; n++) @(negedge clk);
    chk("halted", 32'(go), 32'(inDebug));
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    {localRst, psel, penable, pwrite, dbgEvent, dbgEventIsBkpt, excActive} = '0;
    {excIsHardFault, excIsReset, excPostpone, slow} = '0;
    {paddr, pwdata, bkptPc, nextPc, handlerPc} = '0;
    coreQuiet = 1'b1;
    rst = 1'b1;
    seed = 89;
    nVc = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, DCV_OFS_MONCTL, 32'h0, rd);
    chk("monitor reset", MON_RESET_VAL, rd);
    apb(1'b1, DCV_OFS_MONCTL, 32'hffff_ffff, rd);
    apb(1'b0, DCV_OFS_MONCTL, 32'h0, rd);
    chk("monitor bits", 32'h0100_0401, rd);
    chk("watch enable", 32'h1, 32'(watchUnitEnable));
    @(posedge clk);
    localRst <= 1'b1;
    @(posedge clk);
    localRst <= 1'b0;
    apb(1'b0, DCV_OFS_MONCTL, 32'h0, rd);
    chk("after local reset", 32'h0000_0401, rd);
    apb(1'b0, 12'h010, 32'h0, rd);
    chk("unmapped error", 32'h1, 32'(lastErr));
    halt_on(2, 32'h0000_1000, 1'b0);
    apb(1'b1, DCV_OFS_HALTCS, 32'h1, rd);
    excPostpone <= 1'b1;
    halt_on(2, 32'h0000_2000, 1'b0);
    @(posedge clk);
    excPostpone <= 1'b0;
    repeat (3) @(negedge clk);
    chk("postponed catch", 32'h1, 32'(inDebug));
    xfer(IDX_RESUME, 1'b0, 32'h0, rd);
    chk("postponed resume", 32'h0000_2000, rd);
    apb(1'b1, DCV_OFS_HALTCS, 32'h1, rd);
    for (j = 0; j < 20 && coreResume !== 1'b1; j++) @(negedge clk);
    chk("postponed exit", 32'h1, 32'(coreResume));
    for (k = 0; k < 4; k++) begin
      pc = $random(seed);
      nV0 = nVc;
      halt_on(k, pc, 1'b1);
      chk("catch pulses", 32'(k > 1), 32'(nVc - nV0));
      xfer(IDX_RESUME, 1'b0, 32'h0, rd);
      chk("resume address", even(pc), rd);
      if (k == 0) begin
        for (j = 0; j < 6; j++) begin
          idx = (j == 0) ? IDX_PSR : 5'($random(seed));
          if (idx == IDX_RESUME) idx = 5'h00;
          d = (j == 0) ? 32'hffff_ffff : $random(seed);
          xfer(idx, 1'b1, d, rd);
          xfer(idx, 1'b0, 32'h0, rd);
          chk("core register", d, rd);
          slow <= 1'($random(seed));
        end
        pc = $random(seed) | 32'h1;
        xfer(IDX_RESUME, 1'b1, pc, rd);
        xfer(IDX_RESUME, 1'b0, 32'h0, rd);
        chk("resume written", even(pc), rd);
      end
      apb(1'b1, DCV_OFS_HALTCS, 32'h1, rd);
      for (j = 0; j < 20 && coreResume !== 1'b1; j++) @(negedge clk);
      chk("resume pc", even(pc), coreResumePc);
    end
    report_and_stop();
  end
endmodule
